// [hw/eiu_pkg.sv]
// Package: constants, register map and carriers for the external pin irq unit
package eiu_pkg;

  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00; // core_control_reg sense a/b
  localparam logic [7:0] CSR_OFS    = 8'h04; // core_control_status_reg
  localparam logic [7:0] EN_OFS     = 8'h08; // pin_irq_enable_reg
  localparam logic [7:0] FLAG_OFS   = 8'h0c; // pin_irq_flag_reg
  localparam logic [7:0] SLEEP_OFS  = 8'h10; // sleep / wake control
  localparam logic [7:0] STAT_OFS   = 8'h14; // live pin and request state

  // Field positions
  localparam int SENSE_A_LSB  = 0;  // ctrl [1:0]
  localparam int SENSE_B_LSB  = 2;  // ctrl [3:2]
  localparam int SENSE_C_BIT  = 6;  // csr bit 6
  localparam int PIN_C_BIT    = 5;  // enable/flag bit 5
  localparam int PIN_A_BIT    = 6;  // enable/flag bit 6
  localparam int PIN_B_BIT    = 7;  // enable/flag bit 7
  localparam int SLEEP_LSB    = 0;  // sleep [2:0] mode
  localparam int SUT_LSB      = 4;  // sleep [5:4] startup_time_select
  localparam int STAT_PIN_LSB  = 0; // status [2:0] synchronised pins
  localparam int STAT_REQ_LSB  = 4; // status [6:4] live requests
  localparam int STAT_WAKE_LSB = 8; // status [9:8] wake state

  // Pins rest high, so edge history starts there to avoid a false edge
  localparam logic [2:0] PIN_IDLE = 3'h7;

  // Wake-up timing: watchdog oscillator period and start-up steps
  localparam int WDT_PERIOD_NS = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WDT_DIV = (WDT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUT_BASE_TICKS = 4; // watchdog ticks per startup step

  // Sense encodings for pins a and b
  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } eiu_sense_type;

  // Sleep modes
  typedef enum logic [2:0] {
    SLP_RUN  = 3'b000,
    SLP_IDLE = 3'b001,
    SLP_DEEP = 3'b010
  } eiu_sleep_type;

  // Wake sequencer states
  typedef enum logic [1:0] {
    WK_AWAKE   = 2'b00,
    WK_ASLEEP  = 2'b01,
    WK_QUALIFY = 2'b10,
    WK_STARTUP = 2'b11
  } eiu_wake_type;

  // APB request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } eiu_apb_req_type;

  // APB answer carrier
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } eiu_apb_rsp_type;

endpackage

// [hw/eiu_top.sv]
// External pin interrupt unit with APB registers and wake-up sequencer
// Behaviour
// - Three pins, each own request output
// - Pin used as output still interrupts
// - Pins a,b level/edge; pin c edge only
// - Level mode requests while pin low
// - Pin a,b edges need I/O clock
// - Low level and pin c edges clockless
// - Clockless conditions wake from any sleep
// - I/O clock stops outside idle sleep
// - Level wake outside idle sampled on two watchdog ticks; idle wakes at once
// - Wake if qualified or held to startup end
// - Level gone at startup end: no irq
// - Startup length from startup_time_select bits
// - Sense a/b: low, change, fall, rise
// - Pin c sense: 0 fall, 1 rise
// - Flag set on event, cleared by ack/write-one
// - Level mode: flag clear, request follows pin
module eiu_top
  import eiu_pkg::*;
#(
  parameter int WDT_DIV_P = WDT_DIV
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire eiu_pkg::eiu_apb_req_type apb_req,
  output      eiu_pkg::eiu_apb_rsp_type apb_rsp,
  input  wire logic                    ext_irq_pin_a,
  input  wire logic                    ext_irq_pin_b,
  input  wire logic                    ext_irq_pin_c,
  input  wire logic [2:0]              irq_ack,
  output      logic [2:0]              irq_req,
  output      logic                    io_clk_en,
  output      logic                    wake_req,
  output      logic                    cpu_awake
);
  import eiu_pkg::*;

  // All state of the unit
  typedef struct packed {
    logic [1:0]   sense_a;
    logic [1:0]   sense_b;
    logic         sense_c;
    logic [2:0]   enable;   // {b, a, c}
    logic [2:0]   flag;     // {b, a, c}
    logic [2:0]   sleep;
    logic [1:0]   startup_time_select;
    logic [2:0]   meta;     // first synchroniser stage
    logic [2:0]   sync;     // second synchroniser stage
    logic [2:0]   prev;     // previous sample for edges
    logic [15:0]  div_cnt;
    logic [1:0]   qual;     // watchdog-tick level samples
    logic [7:0]   sut_cnt;
    eiu_wake_type wk;
    logic         latched;  // level qualified on two samples
    logic [31:0]  prdata;
  } eiu_state_type;

  eiu_state_type s_q;
  eiu_state_type s_d;

  logic          wr_en;
  logic          rd_en;
  logic          wdt_tick;
  logic          edge_a;
  logic          edge_b;
  logic          edge_c;
  logic          lvl_a;
  logic          lvl_b;
  logic          lvl_any;
  logic          io_clk_run;
  logic [2:0]    flag_clr;
  logic [7:0]    sut_len;

  // APB strobes: one-cycle access, always ready
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = 1'b0;
  assign apb_rsp.prdata  = s_q.prdata;

  // Watchdog-oscillator tick derived by a divider
  assign wdt_tick = (s_q.div_cnt == 16'(WDT_DIV_P - 1));

  // I/O clock runs while awake or in idle only
  assign io_clk_run = (s_q.wk == WK_AWAKE) ||
                      (s_q.sleep == SLP_IDLE);

  // Level detection is a plain gate on the synchronised pin
  assign lvl_a = (s_q.sense_a == SENSE_LOW) && !s_q.sync[0];
  assign lvl_b = (s_q.sense_b == SENSE_LOW) && !s_q.sync[1];
  assign lvl_any = (lvl_a && s_q.enable[PIN_A_BIT-PIN_C_BIT]) ||
                   (lvl_b && s_q.enable[PIN_B_BIT-PIN_C_BIT]);

  // Edge decode from current against previous sample
  function automatic logic edge_hit(input logic [1:0] sense,
                                    input logic cur, input logic old);
    logic hit;
    hit = 1'b0;
    case (sense)
      SENSE_ANY:  hit = cur ^ old;
      SENSE_FALL: hit = old && !cur;
      SENSE_RISE: hit = !old && cur;
      default:    hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Pins a,b edges only while the I/O clock runs; pin c always
  assign edge_a = io_clk_run &&
                  edge_hit(s_q.sense_a, s_q.sync[0], s_q.prev[0]);
  assign edge_b = io_clk_run &&
                  edge_hit(s_q.sense_b, s_q.sync[1], s_q.prev[1]);
  assign edge_c = s_q.sense_c ? (!s_q.prev[2] && s_q.sync[2])
                              : (s_q.prev[2] && !s_q.sync[2]);

  // Start-up length in watchdog ticks from the select bits
  assign sut_len = 8'(SUT_BASE_TICKS) << s_q.startup_time_select;

  // Flag clears: service acknowledge or write-one
  always_comb begin
    flag_clr = irq_ack;
    if (wr_en && apb_req.paddr == FLAG_OFS) begin
      flag_clr = flag_clr | apb_req.pwdata[PIN_B_BIT:PIN_C_BIT];
    end
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Pin value is seen whatever its direction
    s_d.meta = {ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a};
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.div_cnt = wdt_tick ? 16'h0000 : s_q.div_cnt + 16'h0001;

    // Flags: set beats clear so no event is lost
    s_d.flag = s_q.flag & ~flag_clr;
    if (edge_c) begin
      s_d.flag[0] = 1'b1;
    end
    if (edge_a) begin
      s_d.flag[1] = 1'b1;
    end
    if (edge_b) begin
      s_d.flag[2] = 1'b1;
    end
    if (s_q.sense_a == SENSE_LOW) begin
      s_d.flag[1] = 1'b0;
    end
    if (s_q.sense_b == SENSE_LOW) begin
      s_d.flag[2] = 1'b0;
    end

    // Register writes
    if (wr_en) begin
      case (apb_req.paddr)
        CTRL_OFS: begin
          s_d.sense_a = apb_req.pwdata[SENSE_A_LSB +: 2];
          s_d.sense_b = apb_req.pwdata[SENSE_B_LSB +: 2];
        end
        CSR_OFS:   s_d.sense_c = apb_req.pwdata[SENSE_C_BIT];
        EN_OFS:    s_d.enable = apb_req.pwdata[PIN_B_BIT:PIN_C_BIT];
        SLEEP_OFS: begin
          s_d.sleep = apb_req.pwdata[SLEEP_LSB +: 3];
          s_d.startup_time_select   = apb_req.pwdata[SUT_LSB +: 2];
        end
        default: ;
      endcase
    end

    // Register reads, taken in setup so data is ready in access
    if (rd_en) begin
      s_d.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        CTRL_OFS: begin
          s_d.prdata[SENSE_A_LSB +: 2] = s_q.sense_a;
          s_d.prdata[SENSE_B_LSB +: 2] = s_q.sense_b;
        end
        CSR_OFS:   s_d.prdata[SENSE_C_BIT] = s_q.sense_c;
        EN_OFS:    s_d.prdata[PIN_B_BIT:PIN_C_BIT] = s_q.enable;
        FLAG_OFS:  s_d.prdata[PIN_B_BIT:PIN_C_BIT] = s_q.flag;
        SLEEP_OFS: begin
          s_d.prdata[SLEEP_LSB +: 3] = s_q.sleep;
          s_d.prdata[SUT_LSB +: 2]   = s_q.startup_time_select;
        end
        STAT_OFS: begin
          s_d.prdata[STAT_PIN_LSB +: 3]  = s_q.sync;
          s_d.prdata[STAT_REQ_LSB +: 3]  = irq_req;
          s_d.prdata[STAT_WAKE_LSB +: 2] = s_q.wk;
        end
        default: ;
      endcase
    end

    // Wake sequencer
    case (s_q.wk)
      WK_AWAKE: begin
        if (s_q.sleep != SLP_RUN &&
            !(wr_en && apb_req.paddr == SLEEP_OFS)) begin
          s_d.wk = WK_ASLEEP;
          s_d.latched = 1'b0;
        end
      end
      WK_ASLEEP: begin
        // Clockless sources wake from any sleep depth
        if (|(s_q.flag & s_q.enable) || (edge_c && s_q.enable[0])) begin
          s_d.wk = WK_STARTUP;
          s_d.sut_cnt = 8'h00;
        end else if (lvl_any && s_q.sleep == SLP_IDLE) begin
          s_d.wk = WK_STARTUP;
          s_d.sut_cnt = 8'h00;
        end else if (lvl_any) begin
          s_d.wk = WK_QUALIFY;
          s_d.qual = 2'b00;
        end
      end
      WK_QUALIFY: begin
        if (wdt_tick) begin
          s_d.qual = {s_q.qual[0], lvl_any};
          if (s_q.qual[0] && lvl_any) begin
            s_d.latched = 1'b1;
            s_d.wk = WK_STARTUP;
            s_d.sut_cnt = 8'h00;
          end else if (!lvl_any) begin
            s_d.wk = WK_ASLEEP;
          end
        end
      end
      WK_STARTUP: begin
        if (wdt_tick) begin
          s_d.sut_cnt = s_q.sut_cnt + 8'h01;
          if (s_q.sut_cnt == sut_len - 8'h01) begin
            s_d.wk = WK_AWAKE;
            s_d.sleep = SLP_RUN;
          end
        end
      end
      default: s_d.wk = WK_AWAKE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.sync <= PIN_IDLE;
      s_q.meta <= PIN_IDLE;
      s_q.prev <= PIN_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Requests: level follows the pin only when awake, so a level
  // gone before start-up ends raises nothing
  assign irq_req[0] = s_q.enable[0] && s_q.flag[0];
  assign irq_req[1] = s_q.enable[1] && (s_q.flag[1] ||
                      (lvl_a && s_q.wk == WK_AWAKE));
  assign irq_req[2] = s_q.enable[2] && (s_q.flag[2] ||
                      (lvl_b && s_q.wk == WK_AWAKE));
  assign io_clk_en = io_clk_run;
  assign wake_req  = (s_q.wk == WK_STARTUP);
  assign cpu_awake = (s_q.wk == WK_AWAKE);

  // Assertions
  property p_lvl_follow;
    @(posedge pclk) disable iff (!presetn)
    (cpu_awake && s_q.enable[1] && s_q.sense_a == SENSE_LOW && !s_q.sync[0])
      |-> irq_req[1];
  endproperty
  a_lvl_follow: assert property (p_lvl_follow) else $error("no level");

  property p_lvl_noflag;
    @(posedge pclk) disable iff (!presetn)
    (s_q.sense_a == SENSE_LOW) |=> !s_q.flag[1];
  endproperty
  a_lvl_noflag: assert property (p_lvl_noflag) else $error("flag set");

  property p_fall_c;
    @(posedge pclk) disable iff (!presetn)
    (!s_q.sense_c && s_q.prev[2] && !s_q.sync[2]) |=> s_q.flag[0];
  endproperty
  a_fall_c: assert property (p_fall_c) else $error("c edge missed");

  property p_no_edge_deep;
    @(posedge pclk) disable iff (!presetn)
    (!io_clk_run && !s_q.flag[1] && s_q.sense_a != SENSE_LOW)
      |=> !s_q.flag[1];
  endproperty
  a_no_edge_deep: assert property (p_no_edge_deep) else $error("edge");

  property p_clk_stop;
    @(posedge pclk) disable iff (!presetn)
    (s_q.wk == WK_ASLEEP && s_q.sleep == SLP_DEEP) |-> !io_clk_en;
  endproperty
  a_clk_stop: assert property (p_clk_stop) else $error("clk runs");

  sequence s_two_samples;
    s_q.wk == WK_QUALIFY && wdt_tick && s_q.qual[0] && lvl_any;
  endsequence
  property p_qualify;
    @(posedge pclk) disable iff (!presetn)
    s_two_samples |=> wake_req;
  endproperty
  a_qualify: assert property (p_qualify) else $error("no wake");

  property p_rise_a;
    @(posedge pclk) disable iff (!presetn)
    (io_clk_run && s_q.sense_a == SENSE_RISE && !s_q.prev[0] && s_q.sync[0])
      |=> s_q.flag[1];
  endproperty
  a_rise_a: assert property (p_rise_a) else $error("rise missed");

  property p_ack_clr;
    @(posedge pclk) disable iff (!presetn)
    (irq_ack[0] && !edge_c) |=> !s_q.flag[0];
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("no clear");

endmodule

// [test/eiu_pin_src.sv]
// Off-chip source model driving the three external interrupt pins
module eiu_pin_src (
  input  wire logic       clk,
  output      logic [2:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bits are {b,a,c}; lines rest high as with a pull-up
  initial pins = 3'h7;
  // Change one pin after an edge, then hold it n cycles
  task automatic drive(input int idx, input logic v, input int n);
    pins[idx] <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule

// [test/tb_eiu_top.sv]
// Self-checking bench for the external pin interrupt unit
module tb_eiu_top;
  import eiu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 2; // Short watchdog tick keeps the run brief
  logic            pclk, presetn;
  eiu_apb_req_type req;
  eiu_apb_rsp_type rsp;
  logic [2:0]      pins, ack, irq;
  logic            io_en, wake, awake;
  logic [31:0]     rd;
  int              err_total, compares, seed, n, n0, s, p, b;

  eiu_top #(.WDT_DIV_P(DIV)) u_eiu_top (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .ext_irq_pin_a(pins[1]), .ext_irq_pin_b(pins[2]),
    .ext_irq_pin_c(pins[0]), .irq_ack(ack), .irq_req(irq),
    .io_clk_en(io_en), .wake_req(wake), .cpu_awake(awake));
  eiu_pin_src u_eiu_pin_src (.clk(pclk), .pins(pins));

  // 40 MHz clock
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // Closing report and verdict
  task automatic complete_run();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge pclk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_total++;
      complete_run();
    end
    rd = rsp.prdata;
    req <= '0;
    @(posedge pclk); // Idle gap so the next setup is a fresh step
  endtask

  // Wait for the core to be awake, counting start-up cycles
  task automatic to_awake();
    int k;
    n = 0;
    for (k = 0; k < 3000 && awake !== 1'b1; k++) begin
      @(posedge pclk);
      n += int'(wake === 1'b1);
    end
    if (k >= 3000) begin
      err_total++;
      complete_run();
    end
  endtask

  // Main sequence
  initial begin
    seed = 32'h192d;
    err_total = 0;
    compares = 0;
    req = '0;
    ack = '0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, status shows idle-high pins, unmapped reads zero
    apb(1, 8'h18, 32'hff);
    for (int a = 0; a < 7; a++) begin
      apb(0, 8'(a * 4), 0);
      chk(rd, a == 5 ? 32'h7 : 32'h0);
      chk(rsp.pslverr, 1'b0);
    end
    $display("reset test done");
    // Random edge modes on pins a and b; the other pin sits in level mode
    apb(1, EN_OFS, 32'he0);
    for (int i = 0; i < 12; i++) begin
      s = 1 + $unsigned($random(seed)) % 3;
      p = $unsigned($random(seed)) % 2;
      b = p ? PIN_B_BIT : PIN_A_BIT;
      apb(1, CTRL_OFS, 32'(s) << (p ? SENSE_B_LSB : SENSE_A_LSB));
      u_eiu_pin_src.drive(p + 1, 1'b0, 6);
      chk(irq[p + 1], s != SENSE_RISE);
      apb(0, FLAG_OFS, 0);
      chk(rd[b], s != SENSE_RISE);
      apb(1, FLAG_OFS, 32'he0);
      chk(irq[p + 1], 0);
      u_eiu_pin_src.drive(p + 1, 1'b1, 6);
      chk(irq[p + 1], s != SENSE_FALL);
      apb(1, FLAG_OFS, 32'he0);
    end
    $display("edge test done");
    // Level mode: request follows pin, flag held clear
    apb(1, CTRL_OFS, 0);
    u_eiu_pin_src.drive(1, 1'b0, 6);
    chk(irq[1], 1);
    apb(0, FLAG_OFS, 0);
    chk(rd[PIN_A_BIT], 0);
    u_eiu_pin_src.drive(1, 1'b1, 6);
    chk(irq[1], 0);
    $display("level test done");
    // Pin c both sense settings
    for (int e = 0; e < 2; e++) begin
      apb(1, CSR_OFS, 32'(e) << SENSE_C_BIT);
      u_eiu_pin_src.drive(0, 1'b0, 6);
      chk(irq[0], e == 0);
      // Service entry clears the pin c flag too
      ack <= 3'h1;
      @(posedge pclk);
      ack <= 3'h0;
      @(posedge pclk);
      chk(irq[0], 0);
      apb(1, FLAG_OFS, 32'he0);
      u_eiu_pin_src.drive(0, 1'b1, 6);
      chk(irq[0], e == 1);
      apb(1, FLAG_OFS, 32'he0);
    end
    $display("pin c test done");
    // Service acknowledge clears the flag; also edge seen in idle
    apb(1, CTRL_OFS, 32'(SENSE_FALL));
    apb(1, SLEEP_OFS, 32'(SLP_IDLE));
    // Let the edge that enters sleep settle before looking
    @(posedge pclk);
    chk({io_en, awake}, 2'b10);
    u_eiu_pin_src.drive(1, 1'b0, 6);
    chk(irq[1], 1);
    ack <= 3'h2;
    @(posedge pclk);
    ack <= 3'h0;
    repeat (2) @(posedge pclk);
    chk(irq[1], 0);
    u_eiu_pin_src.drive(1, 1'b1, 6);
    apb(1, SLEEP_OFS, 32'(SLP_RUN));
    $display("ack test done");
    // Deep sleep: pin a edge ignored, pin c edge wakes; start-up scales.
    // Pass 0 only lines the bench up with the watchdog tick phase, so
    // the two measured passes differ by whole ticks alone
    apb(1, CSR_OFS, 32'h0);
    for (int t = 0; t < 3; t++) begin
      apb(1, SLEEP_OFS, 32'(SLP_DEEP) | (32'(t >> 1) << SUT_LSB));
      @(posedge pclk);
      chk({io_en, awake}, 0);
      u_eiu_pin_src.drive(1, 1'b0, 6);
      chk(irq[1], 0);
      u_eiu_pin_src.drive(1, 1'b1, 6);
      u_eiu_pin_src.drive(0, 1'b0, 2);
      to_awake();
      chk(irq[0], 1);
      if (t == 1)
        n0 = n;
      u_eiu_pin_src.drive(0, 1'b1, 4);
      apb(1, FLAG_OFS, 32'he0);
    end
    chk(n - n0, 4 * DIV);
    // Level wake: held low gives irq, released early wakes without irq
    apb(1, CTRL_OFS, 0);
    for (int h = 0; h < 2; h++) begin
      apb(1, SLEEP_OFS, 32'(SLP_DEEP));
      u_eiu_pin_src.drive(1, 1'b0, 10);
      if (h == 1)
        u_eiu_pin_src.drive(1, 1'b1, 1);
      to_awake();
      repeat (4) @(posedge pclk);
      chk(irq[1], h == 0);
      u_eiu_pin_src.drive(1, 1'b1, 4);
    end
    $display("sleep test done");
    complete_run();
  end
endmodule
